// *** common/srs_pkg.sv ***
// Operation
// (RQ1) ring rising and held high over 10 ms sets modem change A
// (RQ2) every edge on clear to send sets modem change A
// (RQ3) carrier, data set ready, secondary receive edges set change B by default
// (RQ4) with routing strap those edges set change A and change B stays off
// (RQ5) change A with modem interrupt enable bit 5 raises the interrupt request
// (RQ6) change A is bit 15, read only, cleared by init, reset or status read
// (RQ7) bit 14 shows the ring level
// (RQ8) bit 13 shows the clear to send level
// (RQ9) bit 12 shows the carrier level
// (RQ10) bit framing applies while character sync mode select is clear
// (RQ11) receiver active, bit 11, sets when the first frame character arrives
// (RQ12) check sequence runs over all received data unless inhibited
// (RQ13) primary station: active holds until closing flag, then clears with end mark
// (RQ14) closing flag tests the check register and reinitialises it unless inhibited
// (RQ15) next message first character sets active again with start mark
// (RQ16) flags between messages are dropped without effect
// (RQ17) secondary station compares first character with parameter low byte
// (RQ18) failed address match leaves active clear and hunts for a flag
// (RQ19) active clears on init, reset, receiver enable off, or abort
// (RQ20) modem inputs are synchronised so each change gives one event
package srs_pkg;
    localparam int unsigned ADDR_W       = 3;
    localparam int unsigned DATA_W       = 16;
    localparam logic [2:0]  OFS_RX_CSR   = 3'h0;
    localparam logic [2:0]  OFS_PARAM    = 3'h2;
    localparam int unsigned B_CHG_A      = 15;
    localparam int unsigned B_RING       = 14;
    localparam int unsigned B_CTS        = 13;
    localparam int unsigned B_CARRIER    = 12;
    localparam int unsigned B_RX_ACT     = 11;
    localparam int unsigned B_SEC_RX     = 10;
    localparam int unsigned B_DSR        = 9;
    localparam int unsigned B_RX_EN      = 4;
    localparam int unsigned B_DS_IE      = 5;
    localparam int unsigned B_SEC_TX     = 3;
    localparam int unsigned B_RTS        = 2;
    localparam int unsigned B_DTR        = 1;
    localparam int unsigned B_CHG_B      = 0;
    localparam logic [15:0] CSR_RW_MASK  = 16'h017e;
    localparam logic [15:0] CSR_RESET    = 16'h0000;
    localparam logic [15:0] PARAM_RESET  = 16'h0000;
    localparam int unsigned P_CHAR_SYNC  = 15;
    localparam int unsigned P_SEC_ADDR   = 12;
    localparam int unsigned P_CRC_INH    = 9;
    localparam int unsigned M_RING       = 0;
    localparam int unsigned M_CTS        = 1;
    localparam int unsigned M_CAR        = 2;
    localparam int unsigned M_DSR        = 3;
    localparam int unsigned M_SEC        = 4;
    localparam int unsigned M_LCLK       = 5;
    localparam int unsigned M_LDAT       = 6;
    localparam int unsigned N_SYNC       = 7;
    localparam int unsigned CLK_HZ       = 250_000_000;
    localparam int unsigned RING_MS      = 10;
    localparam int unsigned RING_CYC     = RING_MS * (CLK_HZ / 1000);
    localparam int unsigned RING_CNT_W   = 22;
    localparam logic [2:0]  ONES_STUFF   = 3'h5;
    localparam logic [2:0]  ONES_FLAG    = 3'h6;
    localparam logic [2:0]  ONES_ABORT   = 3'h7;
    localparam logic [2:0]  DLY_LEN      = 3'h7;
    localparam logic [2:0]  CHAR_LAST    = 3'h7;
    localparam logic [15:0] CRC_INIT     = 16'hffff;
    localparam logic [15:0] CRC_POLY     = 16'h8408;
    localparam logic [15:0] CRC_GOOD     = 16'hf0b8;

    typedef enum logic [1:0] {
        RX_HUNT  = 2'b00,
        RX_OPEN  = 2'b01,
        RX_FRAME = 2'b10
    } srs_rx_e;
endpackage : srs_pkg

// *** rtl/srs_rx_status.sv ***
`timescale 1ns/1ns
module srs_rx_status #(
    parameter int unsigned RING_QUAL_CYC = srs_pkg::RING_CYC
) (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic                       ce,
    input  wire logic [srs_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [srs_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [srs_pkg::DATA_W-1:0] reg_rdata,
    input  wire logic                       bus_init,
    input  wire logic                       device_reset,
    input  wire logic                       change_route_strap,
    input  wire logic                       ring_in,
    input  wire logic                       clear_to_send_in,
    input  wire logic                       carrier_in,
    input  wire logic                       data_set_ready_in,
    input  wire logic                       sec_rx_data_in,
    input  wire logic                       link_clk_in,
    input  wire logic                       link_data_in,
    output logic                            data_terminal_ready,
    output logic                            request_to_send,
    output logic                            sec_tx_data,
    output logic                            receiver_active,
    output logic      [7:0]                 rx_char,
    output logic                            rx_char_valid,
    output logic                            rx_start_of_message,
    output logic                            rx_end_of_message,
    output logic                            rx_crc_error,
    output logic                            rx_abort,
    output logic                            modem_irq
);
    import srs_pkg::*;

    // ----------
    // input synchronisers
    // ----------
    logic [N_SYNC-1:0] pin_w;
    logic [N_SYNC-1:0] s1_q;
    logic [N_SYNC-1:0] s2_q;
    logic [N_SYNC-1:0] s3_q;
    logic [N_SYNC-1:0] lvl_q;
    logic [N_SYNC-1:0] agree_w;
    logic [N_SYNC-1:0] chg_w;

    assign pin_w = {link_data_in, link_clk_in, sec_rx_data_in,
                    data_set_ready_in, carrier_in, clear_to_send_in, ring_in};
    // change accepted only once stages two and three agree
    assign agree_w = ~(s2_q ^ s3_q);
    assign chg_w   = agree_w & (s3_q ^ lvl_q);  // [RQ20]

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            lvl_q <= '0;
        end else if (ce) begin
            s1_q  <= pin_w;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            lvl_q <= lvl_q ^ chg_w;  // [RQ20]
        end
    end

    // ----------
    // strap capture after reset release
    // ----------
    logic strap_q;
    logic strap_done_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_q      <= 1'b0;
            strap_done_q <= 1'b0;
        end else if (ce && !strap_done_q) begin
            strap_q      <= change_route_strap;
            strap_done_q <= 1'b1;
        end
    end

    // ----------
    // register decode
    // ----------
    logic        clr_w;
    logic        csr_wr_w;
    logic        csr_rd_w;
    logic        par_wr_w;
    logic [15:0] ctl_q;
    logic [15:0] ctl_d;
    logic [15:0] param_q;
    logic [15:0] param_d;

    assign clr_w    = bus_init | device_reset;
    assign csr_wr_w = reg_wr && (reg_addr == OFS_RX_CSR);
    assign csr_rd_w = reg_rd && (reg_addr == OFS_RX_CSR);
    assign par_wr_w = reg_wr && (reg_addr == OFS_PARAM);

    assign ctl_d   = clr_w    ? CSR_RESET :
                     csr_wr_w ? (reg_wdata & CSR_RW_MASK) : ctl_q;
    assign param_d = clr_w    ? PARAM_RESET :
                     par_wr_w ? reg_wdata : param_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_q   <= CSR_RESET;
            param_q <= PARAM_RESET;
        end else if (ce) begin
            ctl_q   <= ctl_d;
            param_q <= param_d;
        end
    end

    // ----------
    // ring qualification timer
    // ----------
    logic [RING_CNT_W-1:0] ring_cnt_q;
    logic [RING_CNT_W-1:0] ring_cnt_d;
    logic [RING_CNT_W-1:0] ring_lim_w;
    logic                  ring_hit_w;

    assign ring_lim_w = RING_CNT_W'(RING_QUAL_CYC);
    // at most one hit per high period, when the count is one below the limit
    assign ring_hit_w = lvl_q[M_RING] && (ring_cnt_q == ring_lim_w - 1'b1);  // [RQ1]
    assign ring_cnt_d = !lvl_q[M_RING]          ? '0 :
                        (ring_cnt_q == ring_lim_w) ? ring_cnt_q :
                        ring_cnt_q + 1'b1;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ring_cnt_q <= '0;
        end else if (ce) begin
            ring_cnt_q <= ring_cnt_d;
        end
    end

    // ----------
    // modem change flags
    // ----------
    logic grp_w;
    logic set_a_w;
    logic set_b_w;
    logic chg_a_q;
    logic chg_a_d;
    logic chg_b_q;
    logic chg_b_d;
    logic irq_d;

    assign grp_w   = chg_w[M_CAR] | chg_w[M_DSR] | chg_w[M_SEC];
    assign set_a_w = ring_hit_w                     // [RQ1]
                   | chg_w[M_CTS]                   // [RQ2]
                   | (strap_q & grp_w);             // [RQ4]
    assign set_b_w = ~strap_q & grp_w;              // [RQ3] [RQ4]
    // set beats the read clear so no event is lost
    assign chg_a_d = ~clr_w & (set_a_w | (chg_a_q & ~csr_rd_w));  // [RQ6]
    assign chg_b_d = ~clr_w & (set_b_w | (chg_b_q & ~csr_rd_w));
    assign irq_d   = chg_a_d & ctl_d[B_DS_IE];      // [RQ5]

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chg_a_q   <= 1'b0;
            chg_b_q   <= 1'b0;
            modem_irq <= 1'b0;
        end else if (ce) begin
            chg_a_q   <= chg_a_d;
            chg_b_q   <= chg_b_d;
            modem_irq <= irq_d;
        end
    end

    // ----------
    // bit stream decode
    // ----------
    logic       rx_run_w;
    logic       rx_bit_w;
    logic       din_w;
    logic       push_w;
    logic       flag_w;
    logic       abort_w;
    logic       emit_w;
    logic       ebit_w;
    logic       char_done_w;
    logic [7:0] char_w;
    logic       addr_ok_w;
    logic       crc_inh_w;
    logic       crc_fb_w;
    logic [15:0] crc_nx_w;

    srs_rx_e    st_q;
    srs_rx_e    st_d;
    logic [2:0] ones_q;
    logic [2:0] ones_d;
    logic [6:0] dly_q;
    logic [6:0] dly_d;
    logic [2:0] dly_n_q;
    logic [2:0] dly_n_d;
    logic [7:0] ch_q;
    logic [7:0] ch_d;
    logic [2:0] bcnt_q;
    logic [2:0] bcnt_d;
    logic [15:0] crc_q;
    logic [15:0] crc_d;
    logic       act_q;
    logic       act_d;
    logic [7:0] char_d;
    logic       char_v_d;
    logic       som_d;
    logic       eom_d;
    logic       crc_err_d;
    logic       abort_d;

    // bit framing only while character sync is deselected
    assign rx_run_w  = ctl_q[B_RX_EN] & ~param_q[P_CHAR_SYNC] & ~clr_w;  // [RQ10] [RQ19]
    assign rx_bit_w  = rx_run_w & chg_w[M_LCLK] & s3_q[M_LCLK];
    assign din_w     = s3_q[M_LDAT];
    assign crc_inh_w = param_q[P_CRC_INH];

    // zero after five ones is stuffing; after six it closes a flag
    assign push_w  = rx_bit_w & (din_w ? (ones_q != ONES_FLAG && ones_q != ONES_ABORT)
                                       : (ones_q != ONES_FLAG && ones_q != ONES_STUFF));
    assign flag_w  = rx_bit_w & ~din_w & (ones_q == ONES_FLAG);
    assign abort_w = rx_bit_w & din_w & (ones_q == ONES_FLAG);

    // seven bit delay so a flag never leaks into data
    assign emit_w      = push_w & (dly_n_q == DLY_LEN) & (st_q != RX_HUNT);
    assign ebit_w      = dly_q[0];
    assign char_done_w = emit_w & (bcnt_q == CHAR_LAST);
    assign char_w      = {ebit_w, ch_q[7:1]};
    assign addr_ok_w   = ~param_q[P_SEC_ADDR] | (char_w == param_q[7:0]);  // [RQ17]

    assign crc_fb_w = crc_q[0] ^ ebit_w;
    assign crc_nx_w = (crc_q >> 1) ^ (crc_fb_w ? CRC_POLY : 16'h0000);

    always_comb begin
        st_d      = st_q;
        ones_d    = ones_q;
        dly_d     = dly_q;
        dly_n_d   = dly_n_q;
        ch_d      = ch_q;
        bcnt_d    = bcnt_q;
        crc_d     = crc_q;
        act_d     = act_q;
        char_d    = rx_char;
        char_v_d  = 1'b0;
        som_d     = 1'b0;
        eom_d     = 1'b0;
        abort_d   = 1'b0;
        crc_err_d = rx_crc_error;
        if (!rx_run_w) begin
            st_d    = RX_HUNT;
            act_d   = 1'b0;  // [RQ19]
            ones_d  = '0;
            dly_n_d = '0;
        end else if (rx_bit_w) begin
            if (din_w) begin
                if (ones_q != ONES_ABORT) begin
                    ones_d = ones_q + 1'b1;
                end
            end else begin
                ones_d = '0;
            end
            if (push_w) begin
                dly_d = {din_w, dly_q[6:1]};
                if (dly_n_q != DLY_LEN) begin
                    dly_n_d = dly_n_q + 1'b1;
                end
            end
            if (emit_w) begin
                ch_d   = char_w;
                bcnt_d = bcnt_q + 1'b1;
                if (!crc_inh_w) begin
                    crc_d = crc_nx_w;  // [RQ12]
                end
            end
            if (char_done_w) begin
                unique case (st_q)
                    RX_OPEN: begin
                        if (addr_ok_w) begin
                            st_d     = RX_FRAME;
                            act_d    = 1'b1;  // [RQ11] [RQ15]
                            som_d    = 1'b1;  // [RQ15]
                            char_v_d = 1'b1;
                            char_d   = char_w;
                        end else begin
                            st_d = RX_HUNT;  // [RQ18]
                        end
                    end
                    RX_FRAME: begin
                        char_v_d = 1'b1;
                        char_d   = char_w;
                    end
                    RX_HUNT: begin
                        st_d = RX_HUNT;
                    end
                    default: begin
                        st_d = RX_HUNT;
                    end
                endcase
            end
            if (flag_w) begin
                // staying in open between frames drops idle flags
                dly_n_d = '0;  // [RQ16]
                bcnt_d  = '0;
                st_d    = RX_OPEN;
                if (!crc_inh_w) begin
                    crc_d = CRC_INIT;  // [RQ14]
                end
                if (st_q == RX_FRAME) begin
                    act_d     = 1'b0;  // [RQ13]
                    eom_d     = 1'b1;  // [RQ13]
                    crc_err_d = ~crc_inh_w & (crc_q != CRC_GOOD);  // [RQ14]
                end
            end
            if (abort_w) begin
                st_d    = RX_HUNT;
                act_d   = 1'b0;  // [RQ19]
                dly_n_d = '0;
                abort_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q    <= RX_HUNT;
            ones_q  <= '0;
            dly_q   <= '0;
            dly_n_q <= '0;
            ch_q    <= '0;
            bcnt_q  <= '0;
            crc_q   <= CRC_INIT;
            act_q   <= 1'b0;
        end else if (ce) begin
            st_q    <= st_d;
            ones_q  <= ones_d;
            dly_q   <= dly_d;
            dly_n_q <= dly_n_d;
            ch_q    <= ch_d;
            bcnt_q  <= bcnt_d;
            crc_q   <= crc_d;
            act_q   <= act_d;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_char             <= '0;
            rx_char_valid       <= 1'b0;
            rx_start_of_message <= 1'b0;
            rx_end_of_message   <= 1'b0;
            rx_crc_error        <= 1'b0;
            rx_abort            <= 1'b0;
        end else if (ce) begin
            rx_char             <= char_d;
            rx_char_valid       <= char_v_d;
            rx_start_of_message <= som_d;
            rx_end_of_message   <= eom_d;
            rx_crc_error        <= crc_err_d;
            rx_abort            <= abort_d;
        end
    end

    // ----------
    // read path and pin outputs
    // ----------
    logic [15:0] csr_view_w;
    logic [15:0] rdata_d;

    assign csr_view_w = ctl_q
                      | (16'(chg_a_q)        << B_CHG_A)    // [RQ6]
                      | (16'(lvl_q[M_RING])  << B_RING)     // [RQ7]
                      | (16'(lvl_q[M_CTS])   << B_CTS)      // [RQ8]
                      | (16'(lvl_q[M_CAR])   << B_CARRIER)  // [RQ9]
                      | (16'(act_q)          << B_RX_ACT)   // [RQ11]
                      | (16'(lvl_q[M_SEC])   << B_SEC_RX)
                      | (16'(lvl_q[M_DSR])   << B_DSR)
                      | (16'(chg_b_q)        << B_CHG_B);
    // parameter register is write only and reads as zero
    assign rdata_d = csr_rd_w ? csr_view_w : 16'h0000;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (ce) begin
            reg_rdata <= rdata_d;
        end
    end

    assign data_terminal_ready = ctl_q[B_DTR];
    assign request_to_send     = ctl_q[B_RTS];
    assign sec_tx_data         = ctl_q[B_SEC_TX];
    assign receiver_active     = act_q;

endmodule : srs_rx_status

// *** testbench/srs_rx_status_sva.sv ***
`timescale 1ns/1ns
module srs_rx_status_sva
    import srs_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        ce,
    input wire logic [2:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        bus_init,
    input wire logic        device_reset,
    input wire logic        clear_to_send_in,
    input wire logic        receiver_active,
    input wire logic        rx_char_valid,
    input wire logic        rx_start_of_message,
    input wire logic        rx_end_of_message,
    input wire logic        rx_abort,
    input wire logic        modem_irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_csr_rd;
        reg_rd && ce && reg_addr == OFS_RX_CSR;
    endsequence
    sequence s_csr_wr;
        reg_wr && ce && reg_addr == OFS_RX_CSR;
    endsequence
    sequence s_cts_calm;
        $stable(clear_to_send_in) [*6];
    endsequence

    property p_rdata_idle;
        !reg_rd && ce |=> reg_rdata == 16'h0000;
    endproperty
    property p_cts_level;
        s_cts_calm ##0 s_csr_rd |=> reg_rdata[B_CTS] == $past(clear_to_send_in);
    endproperty
    property p_start_act;
        rx_start_of_message |-> rx_char_valid && receiver_active;
    endproperty
    property p_rise_start;
        $rose(receiver_active) |-> rx_start_of_message;
    endproperty
    property p_end_clr;
        rx_end_of_message |-> !receiver_active && $past(receiver_active);
    endproperty
    property p_abort_clr;
        rx_abort |-> ##[0:2] !receiver_active;
    endproperty
    property p_init_clr;
        (bus_init || device_reset) && ce |=> !receiver_active ##1 !modem_irq;
    endproperty
    property p_irq_off;
        (s_csr_wr and !reg_wdata[B_DS_IE]) ##1 !reg_wr |=> !modem_irq;
    endproperty
    property p_rx_off;
        (s_csr_wr and !reg_wdata[B_RX_EN]) |-> ##[1:3] !receiver_active;
    endproperty

    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero outside read answer");
    a_cts_level: assert property (p_cts_level)
        else $error("cts status bit wrong");
    a_start_act: assert property (p_start_act)
        else $error("start mark without char or active");
    a_rise_start: assert property (p_rise_start)
        else $error("active rose without start mark");
    a_end_clr: assert property (p_end_clr)
        else $error("end mark without active clearing");
    a_abort_clr: assert property (p_abort_clr)
        else $error("active kept after abort");
    a_init_clr: assert property (p_init_clr)
        else $error("init left active or irq");
    a_irq_off: assert property (p_irq_off)
        else $error("irq with enable clear");
    a_rx_off: assert property (p_rx_off)
        else $error("active kept after receiver off");
endmodule : srs_rx_status_sva

// *** testbench/srs_modem_model.sv ***
`timescale 1ns/1ns
module srs_modem_model
    import srs_pkg::*;
(
    output logic ring,
    output logic cts,
    output logic car,
    output logic dsr,
    output logic sec,
    output logic lclk,
    output logic ldat
);
    logic [4:0] lvl;
    int         ones;
    assign {sec, dsr, car, cts, ring} = lvl;
    initial begin
        lvl  = 5'h00;
        lclk = 1'b0;
        ldat = 1'b0;
        ones = 0;
    end
    // ----------
    // link bits: clock runs only inside frames
    // ----------
    task automatic put_bit(input logic b);
        ldat = b;
        #16 lclk = 1'b1;
        #16 lclk = 1'b0;
    endtask : put_bit
    task automatic put_byte(input logic [7:0] b, input bit raw);
        for (int k = 0; k < 8; k++) begin
            put_bit(b[k]);
            ones = (b[k] && !raw) ? ones + 1 : 0;
            if (ones == 5) begin
                put_bit(1'b0);
                ones = 0;
            end
        end
    endtask : put_byte
    task automatic send_frame(input logic [7:0] d[$], input bit bad);
        logic [15:0] crc;
        crc = CRC_INIT;
        put_byte(8'h7e, 1'b1);
        put_byte(8'h7e, 1'b1);
        foreach (d[i]) begin
            put_byte(d[i], 1'b0);
            for (int k = 0; k < 8; k++)
                crc = (crc >> 1) ^ ((crc[0] ^ d[i][k]) ? CRC_POLY : 16'h0000);
        end
        crc = ~crc ^ {15'h0000, bad};
        put_byte(crc[7:0], 1'b0);
        put_byte(crc[15:8], 1'b0);
        put_byte(8'h7e, 1'b1);
        ldat = ~ldat;
    endtask : send_frame
endmodule : srs_modem_model

// *** testbench/sync_rx_status_and_modem_change_tb.sv ***
`timescale 1ns/1ns
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin err_count++; \
    $display("[FAIL] %s exp %h got %h", n, e, a); end end
module sync_rx_status_and_modem_change_tb;
    import srs_pkg::*;
    logic        clk, rst_n, ce, reg_wr, reg_rd, bus_init, device_reset, strap;
    logic [2:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic [7:0]  rx_char;
    logic        ring, cts, car, dsr, sec, lclk, ldat;
    logic        dtr, rts, stx, act, vld, som, eom, crce, abt, irq;
    logic [7:0]  got[$];
    logic [15:0] bpos[3] = '{16'h1000, 16'h0200, 16'h0400};
    int          err_count, cmp_count, n_som, n_eom, n_abt;

    srs_rx_status #(.RING_QUAL_CYC(20)) u_srs_rx_status (
        .clk, .rst_n, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .bus_init, .device_reset, .change_route_strap(strap), .ring_in(ring),
        .clear_to_send_in(cts), .carrier_in(car), .data_set_ready_in(dsr),
        .sec_rx_data_in(sec), .link_clk_in(lclk), .link_data_in(ldat),
        .data_terminal_ready(dtr), .request_to_send(rts), .sec_tx_data(stx),
        .receiver_active(act), .rx_char, .rx_char_valid(vld),
        .rx_start_of_message(som), .rx_end_of_message(eom), .rx_crc_error(crce),
        .rx_abort(abt), .modem_irq(irq));
    srs_modem_model u_srs_modem_model (
        .ring, .cts, .car, .dsr, .sec, .lclk, .ldat);

    initial clk = 1'b0;
    always #2 clk = ~clk;
    always @(posedge clk) begin
        if (vld) got.push_back(rx_char);
        if (som) n_som++;
        if (eom) n_eom++;
        if (abt) n_abt++;
    end
    // ----------
    // bus cycles and helpers
    // ----------
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr
    task automatic rd_chk(input logic [2:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        `CHK("rdata", e, reg_rdata)
    endtask : rd_chk
    task automatic set_lvl(input int i, input logic v);
        @(posedge clk);
        u_srs_modem_model.lvl[i] <= v;
        repeat (8) @(posedge clk);
    endtask : set_lvl
    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask : do_reset
    task automatic wait_eom(input int n);
        for (int i = 0; i < 400 && n_eom < n; i++) @(posedge clk);
        `CHK("eom", n, n_eom)
    endtask : wait_eom
    task automatic part_frame;
        got.delete();
        u_srs_modem_model.put_byte(8'h7e, 1'b1);
        for (int i = 1; i < 4; i++) u_srs_modem_model.put_byte(8'(i * 17), 1'b0);
        repeat (8) @(posedge clk);
        `CHK("act", 1'b1, act)
    endtask : part_frame
    task automatic final_report;
        if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report

    initial begin
        repeat (100000) @(posedge clk);
        err_count++;
        final_report();
    end
    initial begin
        {ce, reg_wr, reg_rd, bus_init, device_reset, strap} = 6'b100000;
        reg_addr  = 3'h0;
        reg_wdata = 16'h0000;
        rst_n     = 1'b0;
        {err_count, cmp_count, n_som, n_eom, n_abt} = '0;
        do_reset();
        rd_chk(OFS_RX_CSR, CSR_RESET);
        wr(OFS_RX_CSR, 16'hffff);
        rd_chk(OFS_RX_CSR, CSR_RW_MASK);
        rd_chk(3'h6, 16'h0000);
        `CHK("pins", 3'h7, {stx, rts, dtr})
        set_lvl(1, 1'b1);
        `CHK("irq", 1'b1, irq)
        rd_chk(OFS_RX_CSR, CSR_RW_MASK | 16'ha000);
        rd_chk(OFS_RX_CSR, CSR_RW_MASK | 16'h2000);
        set_lvl(1, 1'b0);
        rd_chk(OFS_RX_CSR, CSR_RW_MASK | 16'h8000);
        for (int i = 0; i < 3; i++) begin
            set_lvl(i + 2, 1'b1);
            rd_chk(OFS_RX_CSR, CSR_RW_MASK | bpos[i] | 16'h0001);
            set_lvl(i + 2, 1'b0);
            rd_chk(OFS_RX_CSR, CSR_RW_MASK | 16'h0001);
        end
        set_lvl(0, 1'b1);
        set_lvl(0, 1'b0);
        repeat (30) @(posedge clk);
        rd_chk(OFS_RX_CSR, CSR_RW_MASK);
        set_lvl(0, 1'b1);
        rd_chk(OFS_RX_CSR, CSR_RW_MASK | 16'h4000);
        repeat (30) @(posedge clk);
        rd_chk(OFS_RX_CSR, CSR_RW_MASK | 16'hc000);
        set_lvl(0, 1'b0);
        rd_chk(OFS_RX_CSR, CSR_RW_MASK);
        wr(OFS_RX_CSR, 16'h0010);
        wr(OFS_PARAM, 16'h0000);
        u_srs_modem_model.send_frame('{8'h11, 8'h22, 8'h33}, 1'b0);
        wait_eom(1);
        `CHK("c0", 8'h11, got[0])
        `CHK("c2", 8'h33, got[2])
        `CHK("crc", 1'b0, crce)
        `CHK("act", 1'b0, act)
        u_srs_modem_model.send_frame('{8'h44, 8'h55}, 1'b1);
        wait_eom(2);
        `CHK("crc", 1'b1, crce)
        `CHK("som", 2, n_som)
        wr(OFS_PARAM, 16'h0200);
        u_srs_modem_model.send_frame('{8'h66}, 1'b1);
        wait_eom(3);
        `CHK("crc", 1'b0, crce)
        wr(OFS_PARAM, 16'h8000);
        u_srs_modem_model.send_frame('{8'h77}, 1'b0);
        repeat (20) @(posedge clk);
        `CHK("eom", 3, n_eom)
        wr(OFS_PARAM, 16'h105a);
        u_srs_modem_model.send_frame('{8'h33, 8'h44}, 1'b0);
        repeat (20) @(posedge clk);
        `CHK("som", 3, n_som)
        u_srs_modem_model.send_frame('{8'h5a, 8'h44}, 1'b0);
        wait_eom(4);
        `CHK("som", 4, n_som)
        wr(OFS_PARAM, 16'h0000);
        part_frame();
        u_srs_modem_model.put_byte(8'hff, 1'b1);
        repeat (20) @(posedge clk);
        `CHK("abort", 1, n_abt)
        `CHK("act", 1'b0, act)
        part_frame();
        wr(OFS_RX_CSR, 16'h0000);
        repeat (3) @(posedge clk);
        `CHK("act", 1'b0, act)
        wr(OFS_RX_CSR, 16'h0030);
        set_lvl(1, 1'b1);
        `CHK("irq", 1'b1, irq)
        bus_init <= 1'b1;
        @(posedge clk);
        bus_init <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK("irq", 1'b0, irq)
        rd_chk(OFS_RX_CSR, 16'h2000);
        set_lvl(1, 1'b0);
        device_reset <= 1'b1;
        @(posedge clk);
        device_reset <= 1'b0;
        rd_chk(OFS_RX_CSR, 16'h0000);
        strap <= 1'b1;
        do_reset();
        rd_chk(OFS_RX_CSR, 16'h0000);
        set_lvl(2, 1'b1);
        rd_chk(OFS_RX_CSR, 16'h9000);
        final_report();
    end
endmodule : sync_rx_status_and_modem_change_tb

bind srs_rx_status srs_rx_status_sva u_srs_rx_status_sva (
    .clk, .rst_n, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .bus_init, .device_reset, .clear_to_send_in, .receiver_active, .rx_char_valid,
    .rx_start_of_message, .rx_end_of_message, .rx_abort, .modem_irq);
